// *** inc/hspwm_params.svh ***
// register offsets, field positions, reset values and timing counts of the pwm time base
`ifndef HSPWM_PARAMS_SVH
`define HSPWM_PARAMS_SVH
`define HSPWM_ADDR_W 5
`define HSPWM_OFS_PRESCALE 5'h00
`define HSPWM_OFS_PERIOD 5'h01
`define HSPWM_OFS_SEVT 5'h02
`define HSPWM_OFS_MDUTY 5'h03
`define HSPWM_OFS_CTRL 5'h04
`define HSPWM_OFS_STATUS 5'h05
`define HSPWM_OFS_IRQ_STAT 5'h06
`define HSPWM_OFS_IRQ_MASK 5'h07
`define HSPWM_OFS_COUNTER 5'h08
`define HSPWM_OFS_DEAD_RISE 5'h09
`define HSPWM_OFS_DEAD_FALL 5'h0A
`define HSPWM_OFS_CHOP_DIV 5'h0B
`define HSPWM_OFS_TRIG_BASE 5'h10
`define HSPWM_OFS_STRIG_BASE 5'h14
`define HSPWM_OFS_PDUTY_BASE 5'h18
`define HSPWM_PRESCALE_W 3
`define HSPWM_PRESCALE_RESERVED 3'h7
`define HSPWM_RST_PRESCALE 3'h0
`define HSPWM_RST_PERIOD 16'hFFF8
`define HSPWM_RST_ZERO16 16'h0000
`define HSPWM_CMP_LOW_MASK 16'hFFF8
`define HSPWM_DUTY_MIN 16'h0009
`define HSPWM_DUTY_TOP_MARGIN 16'h0008
`define HSPWM_CTRL_ON_BIT 0
`define HSPWM_CTRL_CHOP_BIT 1
`define HSPWM_CTRL_GEN_EN_LSB 4
`define HSPWM_CTRL_SWAP_LSB 8
`define HSPWM_CTRL_MDUTY_SEL_LSB 12
`define HSPWM_IRQ_SEVT_BIT 0
`define HSPWM_IRQ_TRIG_LSB 1
`define HSPWM_IRQ_STRIG_LSB 4
`define HSPWM_IRQ_FAULT_BIT 7
`define HSPWM_IRQ_W 8
`endif

// *** inc/hspwm_pkg.sv ***
// types shared by the pwm time base
package hspwm_pkg;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } hspwm_bus_req_t;
    typedef struct packed {
        logic high;
        logic low;
    } hspwm_pair_t;
    typedef enum logic [0:0] {HSPWM_DT_IDLE, HSPWM_DT_WAIT} hspwm_dt_state_t;
endpackage : hspwm_pkg

// *** rtl/hspwm_timebase.sv ***
// high-speed pwm master time base, compares, three generators and output stage
// Operation
// - prescaler divides by 1..64, code 7 reserved
// - special event compare bits 15..3, low zero
// - duty pulse clamped between 0x0009 and period-8
// - resolution coarsens near 0% or 100%
// - primary trigger compare fires adc trigger
// - secondary trigger compare fires second trigger
// - three generators, six outputs in pairs
// - chopping ANDs outputs with fast clock
// - timing resolution is one counter step away from 0% and 100%
// - each output has own fault and limit
// - pair pins may be swapped
// - separate rising and falling dead time
// - period and duty change on the fly
// - each generator can be disabled
//
// Implementation choices: strobed register access and the address map.
`include "hspwm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hspwm_timebase #(
    parameter int NGEN = 3,
    parameter int DT_W = 14
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire hspwm_pkg::hspwm_bus_req_t BUS_REQ,
    output logic [15:0] BUS_RDATA,
    input wire logic [2*NGEN-1:0] FAULT_IN,
    input wire logic [2*NGEN-1:0] CURRENT_LIMIT_IN,
    output hspwm_pkg::hspwm_pair_t [NGEN-1:0] PWM_OUT,
    output logic [NGEN-1:0] ADC_TRIGGER,
    output logic [NGEN-1:0] ADC_TRIGGER2,
    output logic SPECIAL_EVENT_TRIGGER,
    output logic IRQ
);
    logic [2:0] input_clock_prescale_select;
    logic [15:0] master_period_value;
    logic [15:0] special_event_compare;
    logic [15:0] master_duty;
    logic [15:0] ctrl;
    logic [15:0] dead_rise;
    logic [15:0] dead_fall;
    logic [15:0] chop_div;
    logic [15:0] primary_trigger_compare [NGEN];
    logic [15:0] secondary_trigger_compare [NGEN];
    logic [15:0] gen_duty [NGEN];
    logic [`HSPWM_IRQ_W-1:0] irq_stat;
    logic [`HSPWM_IRQ_W-1:0] irq_mask;
    logic [`HSPWM_IRQ_W-1:0] irq_set;
    logic [15:0] master_timebase_counter;
    logic [5:0] pre_cnt;
    logic tick;
    logic master_timebase_on;
    logic chop_on;
    logic [15:0] chop_cnt;
    logic chop_clk;
    logic [15:0] period_live;
    logic [15:0] duty_live [NGEN];
    logic [15:0] rdata;
    logic [15:0] wval;

    assign master_timebase_on = ctrl[`HSPWM_CTRL_ON_BIT];
    assign chop_on = ctrl[`HSPWM_CTRL_CHOP_BIT];
    assign wval = BUS_REQ.wdata & `HSPWM_CMP_LOW_MASK;

    // register writes; compares drop their three low bits
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            input_clock_prescale_select <= `HSPWM_RST_PRESCALE;
            master_period_value <= `HSPWM_RST_PERIOD;
            special_event_compare <= `HSPWM_RST_ZERO16;
            master_duty <= `HSPWM_RST_ZERO16;
            ctrl <= `HSPWM_RST_ZERO16;
            dead_rise <= `HSPWM_RST_ZERO16;
            dead_fall <= `HSPWM_RST_ZERO16;
            chop_div <= `HSPWM_RST_ZERO16;
            irq_mask <= '0;
            for (int i = 0; i < NGEN; i++) begin
                primary_trigger_compare[i] <= `HSPWM_RST_ZERO16;
                secondary_trigger_compare[i] <= `HSPWM_RST_ZERO16;
                gen_duty[i] <= `HSPWM_RST_ZERO16;
            end
        end else if (BUS_REQ.wr) begin
            case (BUS_REQ.addr)
                `HSPWM_OFS_PRESCALE: input_clock_prescale_select <= BUS_REQ.wdata[2:0];
                `HSPWM_OFS_PERIOD: master_period_value <= BUS_REQ.wdata;
                `HSPWM_OFS_SEVT: special_event_compare <= BUS_REQ.wdata & `HSPWM_CMP_LOW_MASK;
                `HSPWM_OFS_MDUTY: master_duty <= BUS_REQ.wdata;
                `HSPWM_OFS_CTRL: ctrl <= BUS_REQ.wdata;
                `HSPWM_OFS_IRQ_MASK: irq_mask <= BUS_REQ.wdata[`HSPWM_IRQ_W-1:0];
                `HSPWM_OFS_DEAD_RISE: dead_rise <= BUS_REQ.wdata;
                `HSPWM_OFS_DEAD_FALL: dead_fall <= BUS_REQ.wdata;
                `HSPWM_OFS_CHOP_DIV: chop_div <= BUS_REQ.wdata;
                default: begin
                end
            endcase
            // compare banks take the value with its low bits dropped
            for (int i = 0; i < NGEN; i++) begin
                if (BUS_REQ.addr == (`HSPWM_OFS_TRIG_BASE + 5'(i))) begin
                    primary_trigger_compare[i] <= wval;
                end
                if (BUS_REQ.addr == (`HSPWM_OFS_STRIG_BASE + 5'(i))) begin
                    secondary_trigger_compare[i] <= wval;
                end
                if (BUS_REQ.addr == (`HSPWM_OFS_PDUTY_BASE + 5'(i))) begin
                    gen_duty[i] <= BUS_REQ.wdata;
                end
            end
        end
    end

    // prescaler: divide by 2**code, reserved code stalls the base
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            pre_cnt <= '0;
        end else if (!master_timebase_on) begin
            // held at zero while off so the first tick comes at once
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 6'h01;
        end
    end

    always_comb begin
        tick = 1'b0;
        if (master_timebase_on && input_clock_prescale_select != `HSPWM_PRESCALE_RESERVED) begin
            tick = ((pre_cnt & 6'((7'h01 << input_clock_prescale_select) - 7'h01)) == 6'h00);
        end
    end

    // master counter wraps after period; period and duty reload at wrap
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            master_timebase_counter <= '0;
            period_live <= `HSPWM_RST_PERIOD;
            for (int i = 0; i < NGEN; i++) begin
                duty_live[i] <= `HSPWM_RST_ZERO16;
            end
        end else if (!master_timebase_on) begin
            // while off the live copies follow the registers
            master_timebase_counter <= '0;
            period_live <= master_period_value;
            for (int i = 0; i < NGEN; i++) begin
                duty_live[i] <= ctrl[`HSPWM_CTRL_MDUTY_SEL_LSB+i] ? master_duty : gen_duty[i];
            end
        end else if (tick) begin
            if (master_timebase_counter >= period_live) begin
                master_timebase_counter <= '0;
                period_live <= master_period_value;
                for (int i = 0; i < NGEN; i++) begin
                    duty_live[i] <= ctrl[`HSPWM_CTRL_MDUTY_SEL_LSB+i] ? master_duty : gen_duty[i];
                end
            end else begin
                master_timebase_counter <= master_timebase_counter + 16'h0001;
            end
        end
    end

    // compare matches, each qualified by the prescaled tick
    logic sevt_hit;
    logic [NGEN-1:0] trig_hit;
    logic [NGEN-1:0] trig2_hit;
    always_comb begin
        sevt_hit = tick && master_timebase_counter == special_event_compare;
        for (int i = 0; i < NGEN; i++) begin
            trig_hit[i] = tick && ctrl[`HSPWM_CTRL_GEN_EN_LSB+i]
                && master_timebase_counter == primary_trigger_compare[i];
            trig2_hit[i] = tick && ctrl[`HSPWM_CTRL_GEN_EN_LSB+i]
                && master_timebase_counter == secondary_trigger_compare[i];
        end
    end

    // event pulses, one system cycle each
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            SPECIAL_EVENT_TRIGGER <= 1'b0;
            ADC_TRIGGER <= '0;
            ADC_TRIGGER2 <= '0;
        end else begin
            SPECIAL_EVENT_TRIGGER <= sevt_hit;
            ADC_TRIGGER <= trig_hit;
            ADC_TRIGGER2 <= trig2_hit;
        end
    end

    // chopping carrier from a divider of the system clock
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            chop_cnt <= '0;
            chop_clk <= 1'b0;
        end else if (!chop_on) begin
            // carrier parked low while chopping is off
            chop_cnt <= '0;
            chop_clk <= 1'b0;
        end else if (chop_cnt >= chop_div) begin
            chop_cnt <= '0;
            chop_clk <= ~chop_clk;
        end else begin
            chop_cnt <= chop_cnt + 16'h0001;
        end
    end

    // per-generator modulator, dead time and output stage
    logic [NGEN-1:0] raw_pwm;
    logic [NGEN-1:0] gen_en;
    logic [NGEN-1:0] hi_on;
    logic [NGEN-1:0] lo_on;
    logic [NGEN-1:0] prev_raw;
    logic [DT_W-1:0] dt_cnt [NGEN];
    hspwm_pkg::hspwm_dt_state_t dt_state [NGEN];
    logic [15:0] duty_clamp [NGEN];
    logic [15:0] duty_top;
    logic any_fault;

    assign gen_en = ctrl[`HSPWM_CTRL_GEN_EN_LSB +: NGEN];
    assign duty_top = period_live - `HSPWM_DUTY_TOP_MARGIN;

    // clamp keeps pulse inside the edges the pipeline can place
    always_comb begin
        for (int i = 0; i < NGEN; i++) begin
            duty_clamp[i] = duty_live[i];
            if (duty_live[i] < `HSPWM_DUTY_MIN) begin
                duty_clamp[i] = `HSPWM_DUTY_MIN;
            end else if (duty_live[i] > duty_top) begin
                duty_clamp[i] = duty_top;
            end
            // near the ends the edge lands on a coarser step
            if (duty_clamp[i] < 16'h0010 || duty_clamp[i] > duty_top - 16'h0008) begin
                duty_clamp[i] = duty_clamp[i] | 16'h0003;
            end
            raw_pwm[i] = gen_en[i] && master_timebase_on && master_timebase_counter < duty_clamp[i];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            prev_raw <= '0;
            hi_on <= '0;
            lo_on <= '0;
            for (int i = 0; i < NGEN; i++) begin
                dt_cnt[i] <= '0;
                dt_state[i] <= hspwm_pkg::HSPWM_DT_IDLE;
            end
        end else begin
            prev_raw <= raw_pwm;
            for (int i = 0; i < NGEN; i++) begin
                if (!gen_en[i]) begin
                    // disabled generator holds both switches off and its dead time idle
                    hi_on[i] <= 1'b0;
                    lo_on[i] <= 1'b0;
                    dt_state[i] <= hspwm_pkg::HSPWM_DT_IDLE;
                    dt_cnt[i] <= '0;
                end else begin
                    case (dt_state[i])
                        hspwm_pkg::HSPWM_DT_IDLE: begin
                            if (raw_pwm[i] != prev_raw[i]) begin
                                hi_on[i] <= 1'b0;
                                lo_on[i] <= 1'b0;
                                dt_cnt[i] <= raw_pwm[i] ? dead_rise[DT_W-1:0] : dead_fall[DT_W-1:0];
                                dt_state[i] <= hspwm_pkg::HSPWM_DT_WAIT;
                            end else begin
                                hi_on[i] <= raw_pwm[i];
                                lo_on[i] <= ~raw_pwm[i];
                            end
                        end
                        hspwm_pkg::HSPWM_DT_WAIT: begin
                            // a new edge during the wait restarts the count
                            if (raw_pwm[i] != prev_raw[i]) begin
                                dt_cnt[i] <= raw_pwm[i] ? dead_rise[DT_W-1:0] : dead_fall[DT_W-1:0];
                            end else if (dt_cnt[i] == '0) begin
                                hi_on[i] <= raw_pwm[i];
                                lo_on[i] <= ~raw_pwm[i];
                                dt_state[i] <= hspwm_pkg::HSPWM_DT_IDLE;
                            end else begin
                                dt_cnt[i] <= dt_cnt[i] - 1'b1;
                            end
                        end
                        default: dt_state[i] <= hspwm_pkg::HSPWM_DT_IDLE;
                    endcase
                end
            end
        end
    end

    // swap, per-pin fault and limit, then chopping
    logic [NGEN-1:0] next_high;
    logic [NGEN-1:0] next_low;
    always_comb begin
        for (int i = 0; i < NGEN; i++) begin
            next_high[i] = ctrl[`HSPWM_CTRL_SWAP_LSB+i] ? lo_on[i] : hi_on[i];
            next_low[i] = ctrl[`HSPWM_CTRL_SWAP_LSB+i] ? hi_on[i] : lo_on[i];
            next_high[i] = next_high[i] && !FAULT_IN[2*i] && !CURRENT_LIMIT_IN[2*i];
            next_low[i] = next_low[i] && !FAULT_IN[2*i+1] && !CURRENT_LIMIT_IN[2*i+1];
            if (chop_on) begin
                next_high[i] = next_high[i] && chop_clk;
                next_low[i] = next_low[i] && chop_clk;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            PWM_OUT <= '0;
        end else begin
            for (int i = 0; i < NGEN; i++) begin
                PWM_OUT[i].high <= next_high[i];
                PWM_OUT[i].low <= next_low[i];
            end
        end
    end

    // sticky interrupt status, set wins over write-one-to-clear
    assign any_fault = |(FAULT_IN | CURRENT_LIMIT_IN);
    always_comb begin
        irq_set = '0;
        irq_set[`HSPWM_IRQ_SEVT_BIT] = SPECIAL_EVENT_TRIGGER;
        irq_set[`HSPWM_IRQ_TRIG_LSB +: NGEN] = ADC_TRIGGER;
        irq_set[`HSPWM_IRQ_STRIG_LSB +: NGEN] = ADC_TRIGGER2;
        irq_set[`HSPWM_IRQ_FAULT_BIT] = any_fault;
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat <= '0;
        end else if (BUS_REQ.wr && BUS_REQ.addr == `HSPWM_OFS_IRQ_STAT) begin
            // an event in the clearing cycle stays set
            irq_stat <= (irq_stat & ~BUS_REQ.wdata[`HSPWM_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

    // read mux, data in the cycle after the strobe
    always_comb begin
        rdata = '0;
        case (BUS_REQ.addr)
            `HSPWM_OFS_PRESCALE: rdata = {13'h0000, input_clock_prescale_select};
            `HSPWM_OFS_PERIOD: rdata = master_period_value;
            `HSPWM_OFS_SEVT: rdata = special_event_compare;
            `HSPWM_OFS_MDUTY: rdata = master_duty;
            `HSPWM_OFS_CTRL: rdata = ctrl;
            `HSPWM_OFS_STATUS: rdata = {7'h00, PWM_OUT, master_timebase_on, tick, 1'b0};
            `HSPWM_OFS_IRQ_STAT: rdata = {8'h00, irq_stat};
            `HSPWM_OFS_IRQ_MASK: rdata = {8'h00, irq_mask};
            `HSPWM_OFS_COUNTER: rdata = master_timebase_counter;
            `HSPWM_OFS_DEAD_RISE: rdata = dead_rise;
            `HSPWM_OFS_DEAD_FALL: rdata = dead_fall;
            `HSPWM_OFS_CHOP_DIV: rdata = chop_div;
            default: begin
                for (int i = 0; i < NGEN; i++) begin
                    if (BUS_REQ.addr == (`HSPWM_OFS_TRIG_BASE + 5'(i))) rdata = primary_trigger_compare[i];
                    if (BUS_REQ.addr == (`HSPWM_OFS_STRIG_BASE + 5'(i))) rdata = secondary_trigger_compare[i];
                    if (BUS_REQ.addr == (`HSPWM_OFS_PDUTY_BASE + 5'(i))) rdata = gen_duty[i];
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            BUS_RDATA <= '0;
        end else if (BUS_REQ.rd) begin
            // zero again once the read cycle is over
            BUS_RDATA <= rdata;
        end else begin
            BUS_RDATA <= '0;
        end
    end
endmodule : hspwm_timebase
`default_nettype wire

// *** verification/hspwm_checker.sv ***
// port-level checks of the pwm time base
`include "hspwm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hspwm_checker #(
    parameter int NGEN = 3,
    parameter int DT_W = 14
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire hspwm_pkg::hspwm_bus_req_t BUS_REQ,
    input wire logic [15:0] BUS_RDATA,
    input wire logic [2*NGEN-1:0] FAULT_IN,
    input wire logic [2*NGEN-1:0] CURRENT_LIMIT_IN,
    input wire hspwm_pkg::hspwm_pair_t [NGEN-1:0] PWM_OUT,
    input wire logic [NGEN-1:0] ADC_TRIGGER,
    input wire logic [NGEN-1:0] ADC_TRIGGER2,
    input wire logic SPECIAL_EVENT_TRIGGER,
    input wire logic IRQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    logic [2*NGEN-1:0] pin_level;
    logic [2*NGEN-1:0] blocked;
    logic both_on;
    always_comb begin
        both_on = 1'b0;
        for (int i = 0; i < NGEN; i++) begin
            pin_level[2*i] = PWM_OUT[i].high;
            pin_level[2*i+1] = PWM_OUT[i].low;
            both_on = both_on | (PWM_OUT[i].high & PWM_OUT[i].low);
        end
    end
    assign blocked = FAULT_IN | CURRENT_LIMIT_IN;
    function automatic logic is_cmp(input logic [4:0] a);
        return a == `HSPWM_OFS_SEVT || (a[4:3] == 2'b10 && a[1:0] != 2'h3);
    endfunction : is_cmp
    chk_rdata_quiet: assert property (!$past(BUS_REQ.rd) |-> BUS_RDATA == 16'h0000)
        else $error("read data outside read cycle");
    chk_prescale_bits: assert property ($past(BUS_REQ.rd) && $past(BUS_REQ.addr) == 5'h00 |-> BUS_RDATA[15:3] == 13'h0000)
        else $error("prescale upper bits not zero");
    chk_cmp_low: assert property ($past(BUS_REQ.rd) && is_cmp($past(BUS_REQ.addr)) |-> BUS_RDATA[2:0] == 3'h0)
        else $error("compare low bits not zero");
    chk_sevt_spacing: assert property (SPECIAL_EVENT_TRIGGER |=> !SPECIAL_EVENT_TRIGGER [*8])
        else $error("special event pulses too close");
    chk_trig_single: assert property ((ADC_TRIGGER & $past(ADC_TRIGGER)) == '0)
        else $error("primary trigger longer than one cycle");
    chk_trig2_single: assert property (ADC_TRIGGER2 != '0 |=> (ADC_TRIGGER2 & $past(ADC_TRIGGER2)) == '0)
        else $error("secondary trigger longer than one cycle");
    chk_fault_off: assert property (($past(blocked) & pin_level) == '0)
        else $error("output driven during fault");
    chk_pair_apart: assert property (!both_on)
        else $error("both switches of a pair on");
    chk_irq_hold: assert property (IRQ && !BUS_REQ.wr |=> IRQ)
        else $error("interrupt dropped without a write");
    cover property (SPECIAL_EVENT_TRIGGER);
    cover property (ADC_TRIGGER2 != '0);
    cover property (blocked != '0);
    cover property ($rose(IRQ));
endmodule : hspwm_checker
bind hspwm_timebase hspwm_checker #(.NGEN(NGEN), .DT_W(DT_W)) i_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA), .FAULT_IN(FAULT_IN), .CURRENT_LIMIT_IN(CURRENT_LIMIT_IN),
    .PWM_OUT(PWM_OUT), .ADC_TRIGGER(ADC_TRIGGER), .ADC_TRIGGER2(ADC_TRIGGER2),
    .SPECIAL_EVENT_TRIGGER(SPECIAL_EVENT_TRIGGER), .IRQ(IRQ));
`default_nettype wire

// *** verification/hspwm_stage_model.sv ***
// power stage and adc model: switch on-times and trigger counts
`timescale 1ns/1ps
`default_nettype none
module hspwm_stage_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] pins,
    input wire logic [5:0] trig,
    output logic [15:0] width [6],
    output logic [15:0] count [6]
);
    logic [15:0] run [6];
    // on-time latched when the gate drive falls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= '{default: 16'h0000};
            width <= '{default: 16'h0000};
            count <= '{default: 16'h0000};
        end else begin
            for (int i = 0; i < 6; i++) begin
                run[i] <= pins[i] ? run[i] + 16'h0001 : 16'h0000;
                if (!pins[i] && run[i] != 16'h0000) width[i] <= run[i];
                count[i] <= count[i] + 16'(trig[i]);
            end
        end
    end
endmodule : hspwm_stage_model
`default_nettype wire

// *** verification/high_speed_pwm_timebase_bench.sv ***
// self-checking bench of the pwm time base
`include "hspwm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module high_speed_pwm_timebase_bench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    hspwm_pkg::hspwm_bus_req_t bus_req = '0;
    logic [15:0] bus_rdata;
    logic [5:0] fault_in = 6'h00, limit_in = 6'h00, pins;
    hspwm_pkg::hspwm_pair_t [2:0] pwm_out;
    logic [2:0] trig, trig2;
    logic sevt, irq;
    logic [15:0] width [6];
    logic [15:0] tcnt [6];
    int fail_count = 0, check_count = 0, cycles = 0;
    integer seed = 32'hA979;
    localparam logic [4:0] WTAB [10] = '{5'h00, 5'h02, 5'h03, 5'h10, 5'h11, 5'h12, 5'h14, 5'h15, 5'h16, 5'h1F};
    assign pins = {pwm_out[2].low, pwm_out[2].high, pwm_out[1].low, pwm_out[1].high, pwm_out[0].low, pwm_out[0].high};
    hspwm_timebase i_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .BUS_REQ(bus_req), .BUS_RDATA(bus_rdata),
        .FAULT_IN(fault_in), .CURRENT_LIMIT_IN(limit_in), .PWM_OUT(pwm_out), .ADC_TRIGGER(trig),
        .ADC_TRIGGER2(trig2), .SPECIAL_EVENT_TRIGGER(sevt), .IRQ(irq));
    hspwm_stage_model i_stage (.clk(clk_sys), .rst_n(reset_n), .pins(pins), .trig({trig2, trig}),
        .width(width), .count(tcnt));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd
    task automatic sevt_gap(output int gap);
        int t0;
        t0 = -1;
        gap = 0;
        for (int n = 0; n < 3000 && gap == 0; n++) begin
            @(posedge clk_sys);
            #1;
            if (sevt === 1'b1 && t0 >= 0) gap = n - t0;
            else if (sevt === 1'b1) t0 = n;
        end
    endtask : sevt_gap
    // ticks the raw pwm stays high with period 0x40
    function automatic logic [15:0] duty_ticks(input logic [15:0] d);
        logic [15:0] c;
        c = (d < 16'h0009) ? 16'h0009 : (d > 16'h0038) ? 16'h0038 : d;
        return (c < 16'h0010 || c > 16'h0030) ? (c | 16'h0003) : c;
    endfunction : duty_ticks
    function automatic logic [15:0] after_ones(input logic [4:0] a);
        case (a)
            5'h00: return 16'h0007;
            5'h03: return 16'hFFFF;
            5'h1F: return 16'h0000;
            default: return 16'hFFF8;
        endcase
    endfunction : after_ones
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        logic [15:0] v, d, m, c, dr, df;
        logic [15:0] t0 [6];
        int gap;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int a = 0; a < 12; a++) begin
            rd(5'(a), v);
            check(v, a == 1 ? 16'hFFF8 : 16'h0000);
        end
        foreach (WTAB[i]) begin
            wr(WTAB[i], 16'hFFFF);
            rd(WTAB[i], v);
            check(v, after_ones(WTAB[i]));
        end
        wr(`HSPWM_OFS_PERIOD, 16'h0010);
        wr(`HSPWM_OFS_SEVT, 16'h0008);
        for (int p = 0; p < 8; p++) begin
            wr(`HSPWM_OFS_CTRL, 16'h0000);
            wr(`HSPWM_OFS_PRESCALE, 16'(p));
            wr(`HSPWM_OFS_CTRL, 16'h0001);
            sevt_gap(gap);
            check(16'(gap), p == 7 ? 16'h0000 : 16'(17 << p));
        end
        wr(`HSPWM_OFS_CTRL, 16'h0000);
        wr(`HSPWM_OFS_PRESCALE, 16'h0000);
        wr(`HSPWM_OFS_PERIOD, 16'h0040);
        for (int g = 0; g < 3; g++) begin
            wr(5'(`HSPWM_OFS_TRIG_BASE + g), 16'h0020);
            wr(5'(`HSPWM_OFS_STRIG_BASE + g), 16'h0030);
        end
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 16'h0000 : 16'h0010 + 16'($unsigned($random(seed)) % 33);
            m = (k == 0) ? 16'hFFFF : 16'h0009 + 16'(k);
            dr = 16'(k % 3);
            df = 16'(k % 4);
            wr(`HSPWM_OFS_PDUTY_BASE, d);
            wr(`HSPWM_OFS_MDUTY, m);
            wr(`HSPWM_OFS_DEAD_RISE, dr);
            wr(`HSPWM_OFS_DEAD_FALL, df);
            wr(`HSPWM_OFS_CTRL, k == 2 ? 16'h2131 : 16'h2031);
            repeat (200) @(posedge clk_sys);
            t0 = tcnt;
            repeat (260) @(posedge clk_sys);
            c = duty_ticks(d);
            check(width[k == 2 ? 1 : 0], c - dr - 16'h0001);
            check(width[k == 2 ? 0 : 1], 16'h0040 - c - df);
            c = duty_ticks(m);
            check(width[2], c - dr - 16'h0001);
            check(width[3], 16'h0040 - c - df);
            check(width[4] | width[5], 16'h0000);
            for (int j = 0; j < 6; j++) check(tcnt[j] - t0[j], j % 3 == 2 ? 16'h0000 : 16'h0004);
        end
        rd(`HSPWM_OFS_COUNTER, v);
        check(16'(v <= 16'h0040), 16'h0001);
        wr(`HSPWM_OFS_CHOP_DIV, 16'h0003);
        wr(`HSPWM_OFS_CTRL, 16'h2033);
        repeat (200) @(posedge clk_sys);
        check(16'(width[0] <= 16'h0004 && width[0] != 16'h0000), 16'h0001);
        wr(`HSPWM_OFS_CTRL, 16'h2031);
        fault_in <= 6'h01;
        limit_in <= 6'h08;
        repeat (100) @(posedge clk_sys);
        rd(`HSPWM_OFS_IRQ_STAT, v);
        check(v & 16'h00B7, 16'h00B7);
        @(posedge clk_sys);
        fault_in <= 6'h00;
        limit_in <= 6'h00;
        wr(`HSPWM_OFS_CTRL, 16'h0030);
        repeat (4) @(posedge clk_sys);
        wr(`HSPWM_OFS_IRQ_STAT, 16'hFFFF);
        wr(`HSPWM_OFS_IRQ_MASK, 16'h0001);
        #1 check({15'h0000, irq}, 16'h0000);
        wr(`HSPWM_OFS_CTRL, 16'h0031);
        repeat (100) @(posedge clk_sys);
        wr(`HSPWM_OFS_CTRL, 16'h0030);
        #1 check({15'h0000, irq}, 16'h0001);
        wr(`HSPWM_OFS_IRQ_MASK, 16'h0000);
        #1 check({15'h0000, irq}, 16'h0000);
        wr(`HSPWM_OFS_IRQ_MASK, 16'h0001);
        wr(`HSPWM_OFS_IRQ_STAT, 16'h0001);
        #1 check({15'h0000, irq}, 16'h0000);
        print_verdict();
    end
endmodule : high_speed_pwm_timebase_bench
`default_nettype wire
